//--- logic/gof_pkg.sv
package gof_pkg;

  // Wishbone register map (byte addresses, one word each)
  localparam logic [7:0] GOF_REG_CTRL = 8'h00;
  localparam logic [7:0] GOF_REG_STATUS = 8'h04;
  localparam logic [7:0] GOF_REG_ERR0 = 8'h08;
  localparam logic [7:0] GOF_REG_ERR1 = 8'h0C;
  localparam logic [7:0] GOF_REG_ERR2 = 8'h10;
  localparam logic [7:0] GOF_REG_OUTX = 8'h14;
  localparam logic [7:0] GOF_REG_OUTY = 8'h18;
  localparam logic [7:0] GOF_REG_OUTZ = 8'h1C;

  // Control register fields
  localparam int GOF_CTRL_MODE = 0;
  localparam int GOF_CTRL_TERM = 1;
  localparam int GOF_CTRL_FROM_SVC = 2;
  localparam int GOF_CTRL_ENTER = 3;
  localparam int GOF_CTRL_SEND_ERR = 4;
  localparam int GOF_CTRL_LATCH = 5;
  localparam logic [31:0] GOF_CTRL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int GOF_STAT_STARTUP = 6;
  localparam int GOF_STAT_TX_BUSY = 8;

  // Error vector positions
  localparam int GOF_ERR_W = 80;
  localparam int GOF_E_TX_FAIL = 57;
  localparam int GOF_E_MISS_Z = 56;
  localparam int GOF_E_MISS_Y = 55;
  localparam int GOF_E_MISS_X = 54;
  localparam int GOF_E_TDEV_Z = 64;
  localparam int GOF_E_TDEV_Y = 63;
  localparam int GOF_E_TDEV_X = 62;
  localparam int GOF_E_TERR_Z = 6;
  localparam int GOF_E_TERR_Y = 5;
  localparam int GOF_E_TERR_X = 4;
  localparam int GOF_E_OVI_Z = 39;
  localparam int GOF_E_OVQ_Z = 38;
  localparam int GOF_E_OVI_Y = 32;
  localparam int GOF_E_OVQ_Y = 31;
  localparam int GOF_E_OVI_X = 25;
  localparam int GOF_E_OVQ_X = 24;

  // Datagram bytes
  localparam logic [7:0] GOF_ID_PLAIN = 8'h2E;
  localparam logic [7:0] GOF_ID_TERM = 8'h2F;
  localparam logic [7:0] GOF_CRC_SEED = 8'hFF;
  localparam logic [7:0] GOF_CRC_POLY = 8'h07;
  localparam logic [7:0] GOF_CR = 8'h0D;
  localparam logic [7:0] GOF_LF = 8'h0A;
  localparam logic [3:0] GOF_LAST_ERR_BYTE = 4'hB;
  localparam logic [3:0] GOF_LAST_TERM_BYTE = 4'hD;

  // Timing
  localparam longint GOF_CLK_HZ = 200_000_000;
  localparam longint GOF_SAMPLE_HZ = 2000;
  localparam int GOF_SAMPLE_CYC = int'(GOF_CLK_HZ / GOF_SAMPLE_HZ);
  localparam int GOF_STARTUP_MS = 1000;
  localparam int GOF_STARTUP_CYC = int'(GOF_CLK_HZ / 1000 * GOF_STARTUP_MS);

  typedef struct packed {
    logic [23:0] z;
    logic [23:0] y;
    logic [23:0] x;
  } gof_axes_t;

  typedef struct packed {
    logic [2:0] tx_fail_unused;
    logic [2:0] miss;
    logic [2:0] tdev;
    logic [2:0] terr;
    logic [2:0] ov_i;
    logic [2:0] ov_q;
  } gof_faults_t;

endpackage : gof_pkg

//--- logic/gof_axis_fmt.sv
`timescale 1ns/1ps
module gof_axis_fmt
  import gof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic [23:0] rate_in,
  input wire logic [23:0] incr_in,
  input wire logic mode_incr,
  input wire logic take,
  output logic [23:0] word
);

  typedef struct packed {
    logic [23:0] last;
    logic [23:0] acc;
    logic [23:0] word;
  } gof_axst_t;

  gof_axst_t st;
  gof_axst_t next_st;

  always_comb begin
    next_st = st;
    if (sample_en) begin
      next_st.last = rate_in;
    end
    if (take) begin
      next_st.word = mode_incr ? st.acc : st.last;
      // Sample landing on the take edge starts the next interval, not lost
      next_st.acc = sample_en ? incr_in : 24'h000000;
    end else if (sample_en) begin
      next_st.acc = st.acc + incr_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word = st.word;

  property p_rate_pick;
    @(posedge ref_clk) disable iff (!rst_n)
      take && !mode_incr |=> word == $past(st.last);
  endproperty
  a_rate_pick: assert property (p_rate_pick) else $error("rate word not last sample");

  property p_incr_sum;
    @(posedge ref_clk) disable iff (!rst_n)
      take && mode_incr |=> word == $past(st.acc);
  endproperty
  a_incr_sum: assert property (p_incr_sum) else $error("angle word not accumulated sum");

endmodule : gof_axis_fmt

//--- logic/gof_crc8.sv
`timescale 1ns/1ps
module gof_crc8
  import gof_pkg::*;
(
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data,
  output logic [7:0] crc_out
);

  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ GOF_CRC_POLY) : (c << 1);
    end
    crc_out = c;
  end

endmodule : gof_crc8

//--- logic/gof_formatter.sv
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - The error datagram is id 0x2E (0x2F when terminated) then ten error bytes MSB first.
// - A CRC-8 with polynomial x^8+x^2+x+1 and seed 0xFF covers all preceding bytes.
// - Error bit 57 is set when a send request arrives while an earlier request is still pending.
// - Error bits 56, 55, 54 flag missing data for Z, Y, X.
// - Error bits 64, 63, 62 flag front-end temperature deviation for Z, Y, X.
// - Error bits 6, 5, 4 flag front-end temperature error for Z, Y, X.
// - Overflow I/Q flags sit at 39/38 for Z, 32/31 for Y and 25/24 for X.
// - On entry to normal mode from init, status bit 6 is held for a fixed period then cleared.
// - Sampling and output continue unchanged during the settling period.
// - Entry straight from service mode skips the settling period.
// - In rate mode each output is the latest internal sample.
// - Rate is a 24-bit two's-complement word, MSB first, LSB 2^-14 deg/s.
// - In angle mode each output is the sum of increments since the last output.
// - Angle is a 24-bit two's-complement word, MSB first, LSB 2^-21 deg.
// - Every axis is sampled at 2000 samples per second whatever the transmit rate.
module gof_formatter
  import gof_pkg::*;
#(
  parameter int STARTUP_CYC = GOF_STARTUP_CYC,
  parameter int SAMPLE_CYC = GOF_SAMPLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire gof_axes_t rate_in,
  input wire gof_axes_t incr_in,
  input wire gof_faults_t faults,
  output logic sample_tick,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic startup_flag
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dat;
    logic ack;
    logic [31:0] smp_cnt;
    logic tick;
    logic [31:0] su_cnt;
    logic su_flag;
    logic tx_fail;
    logic busy;
    logic [3:0] idx;
    logic [7:0] crc;
    logic [79:0] snap;
    logic [7:0] txd;
    logic txv;
    logic pending;
  } gof_st_t;

  gof_st_t st;
  gof_st_t next_st;

  //////////////////////////////////////////////////////////////////////////////
  // Error vector assembly; everything not driven stays zero
  logic [79:0] err_vec;
  always_comb begin
    err_vec = '0;
    err_vec[GOF_E_TX_FAIL] = st.tx_fail;
    err_vec[GOF_E_MISS_Z] = faults.miss[2];
    err_vec[GOF_E_MISS_Y] = faults.miss[1];
    err_vec[GOF_E_MISS_X] = faults.miss[0];
    err_vec[GOF_E_TDEV_Z] = faults.tdev[2];
    err_vec[GOF_E_TDEV_Y] = faults.tdev[1];
    err_vec[GOF_E_TDEV_X] = faults.tdev[0];
    err_vec[GOF_E_TERR_Z] = faults.terr[2];
    err_vec[GOF_E_TERR_Y] = faults.terr[1];
    err_vec[GOF_E_TERR_X] = faults.terr[0];
    err_vec[GOF_E_OVI_Z] = faults.ov_i[2];
    err_vec[GOF_E_OVQ_Z] = faults.ov_q[2];
    err_vec[GOF_E_OVI_Y] = faults.ov_i[1];
    err_vec[GOF_E_OVQ_Y] = faults.ov_q[1];
    err_vec[GOF_E_OVI_X] = faults.ov_i[0];
    err_vec[GOF_E_OVQ_X] = faults.ov_q[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Axis formatters
  logic [23:0] word_x;
  logic [23:0] word_y;
  logic [23:0] word_z;
  logic take;
  logic wb_hit;
  logic wb_wr;
  logic svc_enter;

  assign wb_hit = wb_cyc_i && wb_stb_i && !st.ack;
  assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
  assign svc_enter = wb_wr && (wb_adr_i == GOF_REG_CTRL) && wb_dat_i[GOF_CTRL_ENTER] &&
    wb_dat_i[GOF_CTRL_FROM_SVC];
  assign take = wb_wr && (wb_adr_i == GOF_REG_CTRL) && wb_dat_i[GOF_CTRL_LATCH];

  gof_axis_fmt u_ax_x (
    .ref_clk(ref_clk), .rst_n(rst_n), .sample_en(st.tick),
    .rate_in(rate_in.x), .incr_in(incr_in.x), .mode_incr(st.ctrl[GOF_CTRL_MODE]),
    .take(take), .word(word_x)
  );
  gof_axis_fmt u_ax_y (
    .ref_clk(ref_clk), .rst_n(rst_n), .sample_en(st.tick),
    .rate_in(rate_in.y), .incr_in(incr_in.y), .mode_incr(st.ctrl[GOF_CTRL_MODE]),
    .take(take), .word(word_y)
  );
  gof_axis_fmt u_ax_z (
    .ref_clk(ref_clk), .rst_n(rst_n), .sample_en(st.tick),
    .rate_in(rate_in.z), .incr_in(incr_in.z), .mode_incr(st.ctrl[GOF_CTRL_MODE]),
    .take(take), .word(word_z)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Datagram byte selection and CRC
  logic [7:0] cur_byte;
  logic [7:0] crc_nxt;
  logic term;
  assign term = st.ctrl[GOF_CTRL_TERM];

  always_comb begin
    unique case (st.idx)
      4'h0: cur_byte = term ? GOF_ID_TERM : GOF_ID_PLAIN;
      4'hB: cur_byte = st.crc;
      4'hC: cur_byte = GOF_CR;
      4'hD: cur_byte = GOF_LF;
      default: cur_byte = st.snap[8'(79 - 8 * (int'(st.idx) - 1)) -: 8];
    endcase
  end

  gof_crc8 u_crc (.crc_in(st.crc), .data(cur_byte), .crc_out(crc_nxt));

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    next_st.ack = wb_hit;
    next_st.tick = 1'b0;
    // Free-running sample tick, independent of how often software reads
    if (st.smp_cnt == 32'(SAMPLE_CYC - 1)) begin
      next_st.smp_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.smp_cnt = st.smp_cnt + 32'h0000_0001;
    end

    if (st.su_flag) begin
      if (st.su_cnt == 32'(STARTUP_CYC - 1)) begin
        next_st.su_flag = 1'b0;
      end else begin
        next_st.su_cnt = st.su_cnt + 32'h0000_0001;
      end
    end

    // Transmitter: one byte in flight, advance when accepted
    if (st.txv && tx_ready) begin
      next_st.txv = 1'b0;
      next_st.crc = crc_nxt;
      if (st.idx == (term ? GOF_LAST_TERM_BYTE : GOF_LAST_ERR_BYTE)) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.idx = st.idx + 4'h1;
      end
    end else if (st.busy && !st.txv) begin
      next_st.txd = cur_byte;
      next_st.txv = 1'b1;
    end

    if (st.pending && !st.busy) begin
      next_st.pending = 1'b0;
      next_st.busy = 1'b1;
      next_st.idx = 4'h0;
      next_st.crc = GOF_CRC_SEED;
      next_st.snap = err_vec;
    end

    if (wb_hit) begin
      unique case (wb_adr_i)
        GOF_REG_CTRL: next_st.dat = st.ctrl;
        GOF_REG_STATUS: next_st.dat = {23'h0, st.busy, 1'b0, st.su_flag, 6'h00};
        GOF_REG_ERR0: next_st.dat = err_vec[31:0];
        GOF_REG_ERR1: next_st.dat = err_vec[63:32];
        GOF_REG_ERR2: next_st.dat = {16'h0000, err_vec[79:64]};
        GOF_REG_OUTX: next_st.dat = {8'h00, word_x};
        GOF_REG_OUTY: next_st.dat = {8'h00, word_y};
        GOF_REG_OUTZ: next_st.dat = {8'h00, word_z};
        default: next_st.dat = 32'h0000_0000;
      endcase
    end

    if (wb_wr && wb_adr_i == GOF_REG_CTRL) begin
      next_st.ctrl[2:0] = wb_dat_i[2:0];
      if (wb_dat_i[GOF_CTRL_ENTER]) begin
        // Service-mode return skips settling; init entry arms it
        next_st.su_flag = !wb_dat_i[GOF_CTRL_FROM_SVC];
        next_st.su_cnt = '0;
      end
      if (wb_dat_i[GOF_CTRL_SEND_ERR]) begin
        if (st.pending) begin
          next_st.tx_fail = 1'b1;
        end else begin
          next_st.pending = 1'b1;
        end
      end
    end
    // Status write clears the failure flag; a new failure wins
    if (wb_wr && wb_adr_i == GOF_REG_STATUS && wb_dat_i[0] &&
        !(wb_wr && wb_adr_i == GOF_REG_CTRL)) begin
      next_st.tx_fail = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.ctrl <= GOF_CTRL_RESET;
      st.su_flag <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign sample_tick = st.tick;
  assign tx_data = st.txd;
  assign tx_valid = st.txv;
  assign startup_flag = st.su_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_id_byte;
    @(posedge ref_clk) disable iff (!rst_n)
      tx_valid && st.idx == 4'h0 |-> tx_data == (term ? GOF_ID_TERM : GOF_ID_PLAIN);
  endproperty
  a_id_byte: assert property (p_id_byte) else $error("wrong datagram id");

  property p_crc_seed;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.busy) |-> st.crc == GOF_CRC_SEED;
  endproperty
  a_crc_seed: assert property (p_crc_seed) else $error("crc not seeded");

  property p_tx_fail;
    @(posedge ref_clk) disable iff (!rst_n)
      wb_wr && wb_adr_i == GOF_REG_CTRL && wb_dat_i[GOF_CTRL_SEND_ERR] && st.pending |=>
      err_vec[GOF_E_TX_FAIL];
  endproperty
  a_tx_fail: assert property (p_tx_fail) else $error("bit 57 not set");

  property p_miss;
    @(posedge ref_clk) disable iff (!rst_n)
      err_vec[56:54] == faults.miss;
  endproperty
  a_miss: assert property (p_miss) else $error("missing data bits wrong");

  property p_tdev;
    @(posedge ref_clk) disable iff (!rst_n)
      err_vec[64:62] == faults.tdev && err_vec[6:4] == faults.terr;
  endproperty
  a_tdev: assert property (p_tdev) else $error("temperature bits wrong");

  property p_ovf;
    @(posedge ref_clk) disable iff (!rst_n)
      {err_vec[39], err_vec[38], err_vec[32], err_vec[31], err_vec[25], err_vec[24]} ==
      {faults.ov_i[2], faults.ov_q[2], faults.ov_i[1], faults.ov_q[1],
       faults.ov_i[0], faults.ov_q[0]};
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow bits wrong");

  property p_settle_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      // A service-mode entry may cut the settling period short
      $fell(startup_flag) |->
      ($past(st.su_cnt) == 32'(STARTUP_CYC - 1)) || $past(svc_enter);
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("settle ended early");

  property p_svc_skip;
    @(posedge ref_clk) disable iff (!rst_n)
      svc_enter |=> !startup_flag;
  endproperty
  a_svc_skip: assert property (p_svc_skip) else $error("settle not skipped");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_n)
      err_vec[79:65] == 15'h0000 && err_vec[53:40] == 14'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_tick_period;
    @(posedge ref_clk) disable iff (!rst_n)
      sample_tick |-> $past(st.smp_cnt) == 32'(SAMPLE_CYC - 1);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample tick off period");

  property p_settle_tick;
    @(posedge ref_clk) disable iff (!rst_n)
      startup_flag && st.smp_cnt == 32'(SAMPLE_CYC - 1) |=> sample_tick;
  endproperty
  a_settle_tick: assert property (p_settle_tick) else $error("sampling stalled in settle");

endmodule : gof_formatter

//--- verification/gof_host_model.sv
`timescale 1ns/1ps
module gof_host_model
  import gof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic startup_flag,
  input wire logic slow,
  input wire logic hold
);
  logic [7:0] rx_q[$];
  logic [7:0] crc;
  logic [7:0] id;
  logic ph;
  int idx;
  int crc_bad;
  int invalid_cnt;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction : crc_step

  //////////////////////////////////////////////////////////////////////////////
  // Slow mode accepts every other cycle so the sender must hold its byte
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      ph <= 1'b0;
      idx <= 0;
      crc_bad <= 0;
      invalid_cnt <= 0;
    end else begin
      ph <= ~ph;
      tx_ready <= !hold && (!slow || ph);
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
        if (startup_flag) invalid_cnt <= invalid_cnt + 1;
        if (idx == 11 && tx_data !== crc) crc_bad <= crc_bad + 1;
        crc <= crc_step((idx == 0) ? 8'hFF : crc, tx_data);
        if (idx == 0) id <= tx_data;
        if (idx == (((idx == 0 ? tx_data : id) == GOF_ID_TERM) ? 13 : 11)) idx <= 0;
        else idx <= idx + 1;
      end
    end
  end
endmodule : gof_host_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import gof_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  gof_axes_t rate_v = '0;
  gof_axes_t incr_v = '0;
  gof_faults_t flt = '0;
  logic tick;
  logic [7:0] txd;
  logic txv;
  logic txr;
  logic stf;
  logic slow = 1'b0;
  logic hold = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  logic [31:0] q;
  logic [79:0] ev;
  logic [79:0] ee;

  always #2.5 ref_clk = ~ref_clk;

  gof_formatter #(.STARTUP_CYC(50), .SAMPLE_CYC(20)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rate_in(rate_v), .incr_in(incr_v),
    .faults(flt), .sample_tick(tick), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
    .startup_flag(stf));

  gof_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .startup_flag(stf), .slow(slow), .hold(hold));

  //////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts edges until the next tick seen at an edge
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (tick !== 1'b1);
  endtask : wait_tick

  task automatic rd_err();
    wb(1'b0, GOF_REG_ERR0, 32'h0);
    ev[31:0] = q;
    wb(1'b0, GOF_REG_ERR1, 32'h0);
    ev[63:32] = q;
    wb(1'b0, GOF_REG_ERR2, 32'h0);
    ev[79:64] = q[15:0];
  endtask : rd_err

  function automatic logic [79:0] exp_err(input gof_faults_t f);
    logic [79:0] e;
    e = '0;
    for (int a = 0; a < 3; a++) begin
      e[GOF_E_MISS_X + a] = f.miss[a];
      e[GOF_E_TDEV_X + a] = f.tdev[a];
      e[GOF_E_TERR_X + a] = f.terr[a];
      e[GOF_E_OVI_X + 7 * a] = f.ov_i[a];
      e[GOF_E_OVQ_X + 7 * a] = f.ov_q[a];
    end
    return e;
  endfunction : exp_err

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(1'b0, GOF_REG_STATUS, 32'h0);
    chk(q[GOF_STAT_STARTUP], 1'b1);
    repeat (30) @(posedge ref_clk);
    chk(stf, 1'b1);
    repeat (30) @(posedge ref_clk);
    chk(stf, 1'b0);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, GOF_REG_CTRL, 32'h0000_0008);
    wait_tick(n);
    wait_tick(n);
    chk(n, 20);
    chk(stf, 1'b1);
    // Service-mode entry in mid-settle must drop the flag at once
    wb(1'b1, GOF_REG_CTRL, 32'h0000_000C);
    repeat (3) @(posedge ref_clk);
    chk(stf, 1'b0);
    repeat (60) @(posedge ref_clk);
    // Unused fault inputs must never leak into the vector
    for (int i = 0; i < 18; i++) begin
      flt <= gof_faults_t'(18'h00001 << i);
      repeat (3) @(posedge ref_clk);
      rd_err();
      chk(ev, exp_err(gof_faults_t'(18'h00001 << i)));
    end
    flt <= gof_faults_t'(18'h3A5A5);
    ee = exp_err(gof_faults_t'(18'h3A5A5));
    for (int t = 0; t < 2; t++) begin
      slow <= t[0];
      u_host.rx_q.delete();
      wb(1'b1, GOF_REG_CTRL, 32'h10 + 32'(2 * t));
      n = 0;
      while (u_host.rx_q.size() < 12 + 2 * t && n < 500) begin
        @(posedge ref_clk);
        n++;
      end
      chk(u_host.rx_q[0], t ? GOF_ID_TERM : GOF_ID_PLAIN);
      for (int k = 0; k < 10; k++) chk(u_host.rx_q[1 + k], ee[79 - 8 * k -: 8]);
      if (t == 1) chk({u_host.rx_q[12], u_host.rx_q[13]}, 16'h0D0A);
    end
    chk(80'(u_host.crc_bad), 80'h0);
    chk(80'(u_host.invalid_cnt), 80'h0);
    flt <= '0;
    hold <= 1'b1;
    // First request is in flight, second waits, third finds the slot taken
    wb(1'b1, GOF_REG_CTRL, 32'h10);
    wb(1'b1, GOF_REG_CTRL, 32'h10);
    wb(1'b1, GOF_REG_CTRL, 32'h10);
    rd_err();
    chk(ev, 80'h1 << GOF_E_TX_FAIL);
    hold <= 1'b0;
    do begin
      wb(1'b0, GOF_REG_STATUS, 32'h0);
    end while (q[GOF_STAT_TX_BUSY] !== 1'b0);
    wb(1'b1, GOF_REG_STATUS, 32'h1);
    rd_err();
    chk(ev, 80'h0);
    for (int r = 0; r < 2; r++) begin
      rate_v <= r ? {24'h7FFFFF, 24'h000123, 24'hABCDEF} : {24'h800001, 24'hFFFFFF, 24'h012345};
      wait_tick(n);
      wait_tick(n);
      wb(1'b1, GOF_REG_CTRL, 32'h20);
      for (int a = 0; a < 3; a++) begin
        wb(1'b0, GOF_REG_OUTX + 8'(4 * a), 32'h0);
        chk(q, {8'h00, rate_v[24 * a +: 24]});
      end
    end
    incr_v <= {24'hFFFFF0, 24'h000100, 24'h000007};
    wb(1'b1, GOF_REG_CTRL, 32'h1);
    wait_tick(n);
    repeat (3) @(posedge ref_clk);
    wb(1'b1, GOF_REG_CTRL, 32'h21);
    repeat (3) wait_tick(n);
    repeat (3) @(posedge ref_clk);
    wb(1'b1, GOF_REG_CTRL, 32'h21);
    for (int a = 0; a < 3; a++) begin
      wb(1'b0, GOF_REG_OUTX + 8'(4 * a), 32'h0);
      chk(q, {8'h00, 24'(3 * incr_v[24 * a +: 24])});
    end
    end_sim();
  end
endmodule : tb
